// >>> include/pls_params.svh
`ifndef PLS_PARAMS_SVH
`define PLS_PARAMS_SVH

// register byte offsets
`define PLS_OFS_LINK 12'h0d0
`define PLS_OFS_SLOT 12'h0d4
`define PLS_OFS_IRQ_STAT 12'h0e0
`define PLS_OFS_IRQ_MASK 12'h0e4
`define PLS_OFS_MSG_PEND 12'h0e8

// link state report fields
`define PLS_SPEED_LSB 16
`define PLS_SPEED_MSB 19
`define PLS_WIDTH_LSB 20
`define PLS_WIDTH_MSB 25
`define PLS_TRAIN_ERR_BIT 26
`define PLS_TRAINING_BIT 27
`define PLS_CLK_CFG_BIT 28
`define PLS_DL_ACTIVE_BIT 29

// link reset values
`define PLS_SPEED_2G5 4'h1
`define PLS_SPEED_5G 4'h2
`define PLS_WIDTH_X2 6'h02
`define PLS_WIDTH_X1 6'h01

// slot feature word fields
`define PLS_ATTN_BTN_BIT 0
`define PLS_PWR_CTL_BIT 1
`define PLS_ATTN_IND_BIT 3
`define PLS_PWR_IND_BIT 4
`define PLS_SURPRISE_BIT 5
`define PLS_HP_CAP_BIT 6
`define PLS_LIM_VAL_LSB 7
`define PLS_LIM_VAL_MSB 14
`define PLS_LIM_SCL_LSB 15
`define PLS_LIM_SCL_MSB 16
`define PLS_SLOT_NUM_LSB 19
`define PLS_SLOT_NUM_MSB 31
`define PLS_LIM_VAL_RST 8'h00
`define PLS_LIM_SCL_RST 2'h0
`define PLS_SLOT_NUM_RST 13'h0000

// interrupt status bits
`define PLS_IRQ_TRAIN_ERR 0
`define PLS_IRQ_TRAIN_DONE 1
`define PLS_IRQ_DL_CHANGE 2
`define PLS_IRQ_MSG_SENT 3
`define PLS_IRQ_BITS 4

// cycles after reset release before the strap is taken
`define PLS_STRAP_SETTLE 3'h4

`endif

// >>> include/pls_pkg.sv
package pls_pkg;
  typedef logic [31:0] pls_word_t;
  typedef logic [11:0] pls_addr_t;
  typedef logic [3:0] pls_irq_t;
  typedef enum logic [1:0] {
    PLS_SEL_NONE,
    PLS_SEL_READ,
    PLS_SEL_WRITE
  } pls_access_t;
endpackage

// >>> design/pls_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; output moves only when stages two and three agree
module pls_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 is read by stage2 alone, never by the filter
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // agreement filter rejects a one-cycle glitch between stages
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= 1'b0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule

// >>> design/pls_top.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "pls_params.svh"
module pls_top
  import pls_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0,
  parameter int MSGQ_W = 2
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] NEG_SPEED,
  input wire logic [5:0] NEG_WIDTH,
  input wire logic NEG_UPDATE,
  input wire logic TRAIN_ACTIVE,
  input wire logic TRAIN_FAIL,
  input wire logic TRAIN_L0,
  input wire logic DL_ACTIVE,
  input wire logic SLOT_CLOCK_STRAP,
  input wire logic CLKCFG_LOAD,
  input wire logic CLKCFG_VALUE,
  input wire logic DFLT_LOAD,
  input wire logic [31:0] DFLT_DATA,
  output logic MSG_VALID,
  input wire logic MSG_READY,
  output logic [7:0] MSG_LIMIT_VALUE,
  output logic [1:0] MSG_LIMIT_SCALE,
  output logic IRQ,
  output logic DLL_REPORT_CAP
);
  localparam logic [MSGQ_W-1:0] PEND_MAX = {MSGQ_W{1'b1}};
  localparam logic [MSGQ_W-1:0] PEND_ONE = {{(MSGQ_W-1){1'b0}}, 1'b1};
  localparam logic [5:0] WIDTH_RST = IS_UPSTREAM ? `PLS_WIDTH_X2 : `PLS_WIDTH_X1;

  // link state
  logic [3:0] speed;
  logic [5:0] width;
  logic train_err;
  logic training;
  logic clk_cfg;
  logic dl_active;
  logic strap_level;
  logic strap_taken;
  logic [2:0] settle_cnt;

  // slot feature fields
  logic attn_btn;
  logic pwr_ctl;
  logic attn_ind;
  logic pwr_ind;
  logic surprise;
  logic hp_cap;
  logic [12:0] slot_num;

  // interrupt and message state
  pls_irq_t irq_stat;
  pls_irq_t irq_mask;
  pls_irq_t irq_evt;
  pls_irq_t irq_clr;
  pls_irq_t next_irq_stat;
  logic [MSGQ_W-1:0] pend_cnt;
  logic [MSGQ_W-1:0] next_pend_cnt;
  logic msg_sent;

  // bus decode
  pls_access_t access;
  logic in_access;
  logic aligned;
  logic hit_link;
  logic hit_slot;
  logic hit_stat;
  logic hit_mask;
  logic hit_pend;
  logic hit_any;
  logic stall;
  logic issue_ready;
  logic wr_fire;
  logic wr_slot;
  pls_word_t link_word;
  pls_word_t slot_word;
  pls_word_t rd_mux;

  // strap pin comes from outside the clock domain
  pls_sync u_strap_sync (
    .clk(CLK),
    .srst(SRST),
    .pin(SLOT_CLOCK_STRAP),
    .level(strap_level)
  );

  // address decode; only word-aligned offsets are mapped
  assign aligned = (PADDR[1:0] == 2'h0);
  assign hit_link = aligned && (PADDR == `PLS_OFS_LINK);
  assign hit_slot = aligned && !IS_UPSTREAM && (PADDR == `PLS_OFS_SLOT);
  assign hit_stat = aligned && (PADDR == `PLS_OFS_IRQ_STAT);
  assign hit_mask = aligned && (PADDR == `PLS_OFS_IRQ_MASK);
  assign hit_pend = aligned && (PADDR == `PLS_OFS_MSG_PEND);
  assign hit_any = hit_link || hit_slot || hit_stat || hit_mask || hit_pend;

  // access phase classification
  assign in_access = PSEL && PENABLE;
  assign access = !in_access ? PLS_SEL_NONE : (PWRITE ? PLS_SEL_WRITE : PLS_SEL_READ);

  // hold a slot write off while the message counter is full
  assign stall = (access == PLS_SEL_WRITE) && hit_slot && (pend_cnt == PEND_MAX);
  assign issue_ready = in_access && !PREADY && !stall;

  // a write takes effect on the edge where pready is sampled high
  assign wr_fire = (access == PLS_SEL_WRITE) && PREADY;
  assign wr_slot = wr_fire && hit_slot;

  // reserved link bits 31:30 and low half read as zero
  assign link_word = {
    2'h0,
    dl_active,
    clk_cfg,
    training,
    train_err,
    width,
    speed,
    16'h0000
  };

  // reserved slot bits 18:17 and 2 read as zero
  assign slot_word = {
    slot_num,
    2'h0,
    MSG_LIMIT_SCALE,
    MSG_LIMIT_VALUE,
    hp_cap,
    surprise,
    pwr_ind,
    attn_ind,
    1'b0,
    pwr_ctl,
    attn_btn
  };

  // read selection; unmapped offsets read zero
  assign rd_mux = hit_link ? link_word :
                  hit_slot ? slot_word :
                  hit_stat ? {28'h0000000, irq_stat} :
                  hit_mask ? {28'h0000000, irq_mask} :
                  hit_pend ? {{(32-MSGQ_W){1'b0}}, pend_cnt} :
                  32'h00000000;

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= issue_ready;
      PSLVERR <= issue_ready && !hit_any;
      PRDATA <= (issue_ready && !PWRITE) ? rd_mux : 32'h00000000;
    end
  end

  // speed latched when training reports a result
  always_ff @(posedge CLK) begin
    if (SRST) begin
      speed <= `PLS_SPEED_5G;
    end else if (NEG_UPDATE) begin
      speed <= NEG_SPEED;
    end
  end

  // width reset depends on port direction
  always_ff @(posedge CLK) begin
    if (SRST) begin
      width <= WIDTH_RST;
    end else if (NEG_UPDATE) begin
      width <= NEG_WIDTH;
    end
  end

  // failure wins if both arrive together
  always_ff @(posedge CLK) begin
    if (SRST) begin
      train_err <= 1'b0;
    end else if (TRAIN_FAIL) begin
      train_err <= 1'b1;
    end else if (TRAIN_L0) begin
      train_err <= 1'b0;
    end
  end

  // training and link active mirror the link logic
  always_ff @(posedge CLK) begin
    if (SRST) begin
      training <= 1'b0;
      dl_active <= 1'b0;
    end else begin
      training <= TRAIN_ACTIVE;
      dl_active <= DL_ACTIVE;
    end
  end

  // settle counter lets the synchroniser fill before the strap is taken
  always_ff @(posedge CLK) begin
    if (SRST) begin
      settle_cnt <= 3'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      settle_cnt <= settle_cnt + 3'h1;
      strap_taken <= (settle_cnt == `PLS_STRAP_SETTLE);
    end
  end

  // strap caught once after release; loader override wins over it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clk_cfg <= 1'b0;
    end else if (CLKCFG_LOAD) begin
      clk_cfg <= CLKCFG_VALUE;
    end else if (!strap_taken && (settle_cnt == `PLS_STRAP_SETTLE)) begin
      clk_cfg <= strap_level;
    end
  end

  // slot feature bits are read only to software
  always_ff @(posedge CLK) begin
    if (SRST) begin
      attn_btn <= 1'b0;
      pwr_ctl <= 1'b0;
      attn_ind <= 1'b0;
      pwr_ind <= 1'b0;
      surprise <= 1'b0;
      hp_cap <= 1'b0;
    end else if (DFLT_LOAD) begin
      attn_btn <= DFLT_DATA[`PLS_ATTN_BTN_BIT];
      pwr_ctl <= DFLT_DATA[`PLS_PWR_CTL_BIT];
      attn_ind <= DFLT_DATA[`PLS_ATTN_IND_BIT];
      pwr_ind <= DFLT_DATA[`PLS_PWR_IND_BIT];
      surprise <= DFLT_DATA[`PLS_SURPRISE_BIT];
      hp_cap <= DFLT_DATA[`PLS_HP_CAP_BIT];
    end
  end

  // slot number, only the loader changes it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      slot_num <= `PLS_SLOT_NUM_RST;
    end else if (DFLT_LOAD) begin
      slot_num <= DFLT_DATA[`PLS_SLOT_NUM_MSB:`PLS_SLOT_NUM_LSB];
    end
  end

  // power limit fields; a bus write beats a loader update
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MSG_LIMIT_VALUE <= `PLS_LIM_VAL_RST;
      MSG_LIMIT_SCALE <= `PLS_LIM_SCL_RST;
    end else if (wr_slot) begin
      MSG_LIMIT_VALUE <= PWDATA[`PLS_LIM_VAL_MSB:`PLS_LIM_VAL_LSB];
      MSG_LIMIT_SCALE <= PWDATA[`PLS_LIM_SCL_MSB:`PLS_LIM_SCL_LSB];
    end else if (DFLT_LOAD) begin
      MSG_LIMIT_VALUE <= DFLT_DATA[`PLS_LIM_VAL_MSB:`PLS_LIM_VAL_LSB];
      MSG_LIMIT_SCALE <= DFLT_DATA[`PLS_LIM_SCL_MSB:`PLS_LIM_SCL_LSB];
    end
  end

  // one pending message per slot write; payload is the live value
  assign msg_sent = MSG_VALID && MSG_READY;
  assign next_pend_cnt = wr_slot && !msg_sent ? pend_cnt + PEND_ONE :
                         !wr_slot && msg_sent ? pend_cnt - PEND_ONE :
                         pend_cnt;

  // message valid stays high while any write is unsent
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pend_cnt <= {MSGQ_W{1'b0}};
      MSG_VALID <= 1'b0;
    end else begin
      pend_cnt <= next_pend_cnt;
      MSG_VALID <= (next_pend_cnt != {MSGQ_W{1'b0}});
    end
  end

  // capability only on hot-plug capable downstream ports
  always_ff @(posedge CLK) begin
    if (SRST) begin
      DLL_REPORT_CAP <= 1'b0;
    end else begin
      DLL_REPORT_CAP <= !IS_UPSTREAM && hp_cap;
    end
  end

  // interrupt events; training done and link change from observed edges, training fail and message sent taken as they come
  assign irq_evt[`PLS_IRQ_TRAIN_ERR] = TRAIN_FAIL;
  assign irq_evt[`PLS_IRQ_TRAIN_DONE] = training && !TRAIN_ACTIVE;
  assign irq_evt[`PLS_IRQ_DL_CHANGE] = dl_active != DL_ACTIVE;
  assign irq_evt[`PLS_IRQ_MSG_SENT] = msg_sent;

  // write-one-to-clear; a new event in the same cycle wins over the clear
  assign irq_clr = (wr_fire && hit_stat) ? PWDATA[`PLS_IRQ_BITS-1:0] : 4'h0;
  assign next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

  // sticky status and its mask
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_fire && hit_mask) begin
        irq_mask <= PWDATA[`PLS_IRQ_BITS-1:0];
      end
    end
  end

  // irq registered from next values so it tracks status without lag
  always_ff @(posedge CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_stat & ((wr_fire && hit_mask) ? PWDATA[3:0] : irq_mask));
    end
  end
endmodule

// >>> tb/pls_monitor.sv
`timescale 1ns/1ps
`include "pls_params.svh"
module pls_monitor #(
  parameter bit IS_UPSTREAM = 1'b0
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic DL_ACTIVE,
  input wire logic MSG_VALID,
  input wire logic MSG_READY,
  input wire logic [7:0] MSG_LIMIT_VALUE,
  input wire logic [1:0] MSG_LIMIT_SCALE,
  input wire logic IRQ,
  input wire logic DLL_REPORT_CAP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // completed transfers, decoded once
  wire rd_link = PREADY && !PWRITE && PADDR == `PLS_OFS_LINK;
  wire rd_slot = PREADY && !PWRITE && PADDR == `PLS_OFS_SLOT && !PSLVERR;
  wire wr_slot = PREADY && PWRITE && PADDR == `PLS_OFS_SLOT && !PSLVERR;
  wire [7:0] wr_val = PWDATA[14:7];
  wire [1:0] wr_scl = PWDATA[16:15];
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  chk_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
    else $error("ready without a full access phase");
  chk_link_rsvd: assert property (rd_link |-> PRDATA[31:30] == 2'h0 && PRDATA[15:0] == 16'h0000)
    else $error("reserved link bits not zero");
  chk_slot_rsvd: assert property (rd_slot |-> PRDATA[18:17] == 2'h0 && !PRDATA[2])
    else $error("reserved slot bits not zero");
  chk_dl_bit: assert property (rd_link |-> PRDATA[29] == $past(DL_ACTIVE, 2))
    else $error("data link active bit wrong");
  chk_slot_map: assert property (PREADY && PADDR == `PLS_OFS_SLOT |-> PSLVERR == IS_UPSTREAM)
    else $error("slot word mapping wrong for port kind");
  chk_lim_value: assert property (wr_slot |=> MSG_VALID && MSG_LIMIT_VALUE == $past(wr_val))
    else $error("limit write sent no message or wrong value");
  chk_lim_scale: assert property (wr_slot |=> MSG_LIMIT_SCALE == $past(wr_scl))
    else $error("limit scale payload wrong");
  chk_msg_hold: assert property (MSG_VALID && !MSG_READY |=> MSG_VALID)
    else $error("message dropped before taken");
  chk_cap_bit: assert property (rd_slot |-> PRDATA[6] == DLL_REPORT_CAP && !IS_UPSTREAM)
    else $error("active reporting capability mismatch");
  // main scenarios reached
  cov_wr_slot: cover property (wr_slot);
  cov_msg_taken: cover property (MSG_VALID && MSG_READY);
  cov_irq_rise: cover property ($rose(IRQ));
  cov_slverr: cover property (PREADY && PSLVERR);
  cov_write_stall: cover property (PSEL && PENABLE && !PREADY && $past(PSEL && PENABLE && !PREADY));
endmodule
bind pls_top pls_monitor #(.IS_UPSTREAM(IS_UPSTREAM)) pls_monitor_inst (
  .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DL_ACTIVE(DL_ACTIVE), .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY),
  .MSG_LIMIT_VALUE(MSG_LIMIT_VALUE), .MSG_LIMIT_SCALE(MSG_LIMIT_SCALE), .IRQ(IRQ),
  .DLL_REPORT_CAP(DLL_REPORT_CAP));

// >>> tb/pls_msg_sink.sv
`timescale 1ns/1ps
module pls_msg_sink (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic msg_valid,
  input wire logic [7:0] msg_limit_value,
  input wire logic [1:0] msg_limit_scale,
  output logic msg_ready,
  output int taken,
  output logic [9:0] last
);
  logic [2:0] gap;
  // link side: slow mode takes one message in eight cycles, slower than
  // back-to-back writes, so the pending counter reaches full and stalls
  // one count per taken message
  always_ff @(posedge clk) begin
    if (srst) begin
      gap <= 3'h0;
      msg_ready <= 1'b0;
      taken <= 0;
      last <= 10'h000;
    end else begin
      gap <= gap + 3'h1;
      msg_ready <= !slow || gap == 3'h7;
      if (msg_valid && msg_ready) begin
        taken <= taken + 1;
        last <= {msg_limit_scale, msg_limit_value};
      end
    end
  end
endmodule

// >>> tb/tb_pcie_port_link_slot_status.sv
`timescale 1ns/1ps
`include "pls_params.svh"
module tb_pcie_port_link_slot_status;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d, ddata = 0;
  logic [3:0] nsp = 0, s;
  logic [5:0] nwd = 0, w;
  logic nup = 0, tact = 0, tfail = 0, tl0 = 0, dla = 0, strap = 1, cload = 0, cval = 0;
  logic dload = 0, slow = 0, mvalid, mready, irq, dcap, t, dl;
  logic [7:0] mval;
  logic [1:0] mscl;
  logic [9:0] last;
  logic [31:0] prdata_up, rd_up;
  logic pslverr_up, er_up, dcap_up;
  int taken, i, n, base, miscompares = 0, checks_done = 0;
  always #4 clk = ~clk;
  pls_top #(.IS_UPSTREAM(1'b0), .MSGQ_W(2)) pls_top_inst (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NEG_SPEED(nsp),
    .NEG_WIDTH(nwd), .NEG_UPDATE(nup), .TRAIN_ACTIVE(tact), .TRAIN_FAIL(tfail),
    .TRAIN_L0(tl0), .DL_ACTIVE(dla), .SLOT_CLOCK_STRAP(strap), .CLKCFG_LOAD(cload),
    .CLKCFG_VALUE(cval), .DFLT_LOAD(dload), .DFLT_DATA(ddata), .MSG_VALID(mvalid),
    .MSG_READY(mready), .MSG_LIMIT_VALUE(mval), .MSG_LIMIT_SCALE(mscl), .IRQ(irq),
    .DLL_REPORT_CAP(dcap));
  // upstream port copy on the same bus, for the port-kind dependent fields
  pls_top #(.IS_UPSTREAM(1'b1), .MSGQ_W(2)) pls_top_up_inst (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata_up), .PREADY(), .PSLVERR(pslverr_up), .NEG_SPEED(nsp),
    .NEG_WIDTH(nwd), .NEG_UPDATE(nup), .TRAIN_ACTIVE(tact), .TRAIN_FAIL(tfail),
    .TRAIN_L0(tl0), .DL_ACTIVE(dla), .SLOT_CLOCK_STRAP(strap), .CLKCFG_LOAD(cload),
    .CLKCFG_VALUE(cval), .DFLT_LOAD(dload), .DFLT_DATA(ddata), .MSG_VALID(),
    .MSG_READY(mready), .MSG_LIMIT_VALUE(), .MSG_LIMIT_SCALE(), .IRQ(),
    .DLL_REPORT_CAP(dcap_up));
  pls_msg_sink pls_msg_sink_inst (.clk(clk), .srst(srst), .slow(slow), .msg_valid(mvalid),
    .msg_limit_value(mval), .msg_limit_scale(mscl), .msg_ready(mready), .taken(taken),
    .last(last));
  // expected link word from its fields
  function automatic logic [31:0] lw(logic [3:0] sp, logic [5:0] wd, logic e, tr, c, a);
    return {2'h0, a, c, tr, e, wd, sp, 16'h0000};
  endfunction
  task summarize;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++k < 100);
    if (k >= 100) begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    rd_up = prdata_up;
    er_up = pslverr_up;
    psel <= 0;
    penable <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    n = $urandom(54);
    repeat (20) @(posedge clk);
    srst <= 0;
    repeat (8) @(posedge clk);
    rc(`PLS_OFS_LINK, lw(4'h2, 6'h01, 0, 0, 1, 0)); // reset word
    chk(rd_up, lw(4'h2, 6'h02, 0, 0, 1, 0)); // upstream resets to x2
    rc(`PLS_OFS_SLOT, 32'h0); // slot word reset
    chk(er_up, 1); // no slot word upstream
    $display("test reset done");
    // random negotiated link state
    for (i = 0; i < 6; i++) begin
      s = ($urandom % 2) ? 4'h1 : 4'h2;
      w = 6'h01 << ($urandom % 3);
      t = 1'($urandom);
      dl = 1'($urandom);
      @(posedge clk);
      nsp <= s;
      nwd <= w;
      nup <= 1;
      tact <= t;
      dla <= dl;
      @(posedge clk);
      nup <= 0;
      rc(`PLS_OFS_LINK, lw(s, w, 0, t, 1, dl)); // link fields
    end
    // failed training, then recovery to L0
    @(posedge clk);
    tact <= 0;
    tfail <= 1;
    @(posedge clk);
    tfail <= 0;
    rc(`PLS_OFS_LINK, lw(s, w, 1, 0, 1, dl)); // error flag set
    @(posedge clk);
    tl0 <= 1;
    @(posedge clk);
    tl0 <= 0;
    cload <= 1;
    @(posedge clk);
    cload <= 0;
    rc(`PLS_OFS_LINK, lw(s, w, 0, 0, 0, dl)); // cleared, clock bit loaded
    apb(1, `PLS_OFS_LINK, 32'hffffffff);
    rc(`PLS_OFS_LINK, lw(s, w, 0, 0, 0, dl)); // read-only word ignores writes
    apb(0, 12'h0f0, 32'h0);
    chk({rd[30:0], er}, 32'h1); // unmapped reads zero with error
    apb(0, 12'h0d5, 32'h0);
    chk(er, 1); // unaligned slot access refused
    $display("test link done");
    // power limit writes, fast then stalling partner
    for (i = 0; i < 6; i++) begin
      d = $urandom;
      apb(1, `PLS_OFS_SLOT, d);
      rc(`PLS_OFS_SLOT, d & 32'h0001ff80); // only limit fields take
    end
    slow <= 1;
    base = taken;
    repeat (5) begin
      d = $urandom;
      apb(1, `PLS_OFS_SLOT, d);
    end
    for (n = 0; n < 200 && mvalid !== 1'b0; n++) @(posedge clk);
    if (n >= 200) begin
      miscompares++;
      summarize();
    end
    repeat (2) @(posedge clk);
    chk(taken, base + 5); // one message per write
    chk(last, d[16:7]); // latest value and scale carried
    rc(12'h0e8, 32'h0); // nothing left pending
    $display("test power limit done");
    // loader replaces slot defaults, hot-plug bit both ways
    for (i = 0; i < 2; i++) begin
      d = $urandom;
      d[6] = i[0];
      @(posedge clk);
      dload <= 1;
      ddata <= d;
      @(posedge clk);
      dload <= 0;
      rc(`PLS_OFS_SLOT, d & 32'hfff9fffb); // loaded fields
      chk(dcap, d[6]); // capability follows hot-plug bit
      chk(dcap_up, 0); // upstream capability stays zero
    end
    $display("test loader done");
    // interrupt raise, clear and mask
    apb(1, 12'h0e0, 32'hf);
    apb(1, 12'h0e4, 32'h1);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      tfail <= 1;
      @(posedge clk);
      tfail <= 0;
      repeat (2) @(posedge clk);
      chk(irq, !i[0]); // error event, masked on the second pass
      rc(12'h0e0, 32'h1); // status stays sticky
      // mask off after the first pass, back on after the second
      apb(1, 12'h0e4, 32'(i));
    end
    repeat (2) @(posedge clk);
    chk(irq, 1); // unmasked status raises the line again
    apb(1, 12'h0e0, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 0); // cleared by writing one
    $display("test interrupt done");
    // mid-run reset puts every field back to its reset value
    @(posedge clk);
    srst <= 1;
    dla <= 0;
    repeat (4) @(posedge clk);
    srst <= 0;
    repeat (8) @(posedge clk);
    rc(`PLS_OFS_LINK, lw(4'h2, 6'h01, 0, 0, 1, 0));
    chk(rd_up, lw(4'h2, 6'h02, 0, 0, 1, 0)); // upstream width again
    rc(`PLS_OFS_SLOT, 32'h0); // loaded fields reset
    rc(12'h0e8, 32'h0); // pending count reset
    $display("test mid reset done");
    summarize();
  end
endmodule
